// file: src/isph_pkg.sv
// Shared constants and types for the serial programming host
package isph_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_TX     = 8'h04;
	localparam logic [7:0] OFS_RX     = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	localparam int CTRL_SESSION_BIT = 0;
	localparam int CTRL_WAIT_LSB    = 1;
	localparam int CTRL_START_BIT   = 8;
	localparam int CTRL_PULSE_BIT   = 9;

	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_DONE_BIT     = 1;
	localparam int ST_REFUSED_BIT  = 2;
	localparam int ST_ENABLED_BIT  = 3;
	localparam int ST_ECHO_BIT     = 4;
	localparam int ST_DEV_BUSY_BIT = 5;

	localparam logic [31:0] RESET_TX   = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Instruction bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_ENABLE  = 8'hAC;
	localparam logic [7:0] ECHO_ENABLE = 8'h53;
	localparam logic [7:0] OPC_POLL    = 8'hF0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SCK_HALF_NS     = 400;
	localparam int STARTUP_NS      = 20_000_000;
	localparam int FLASH_WAIT_NS   = 4_500_000;
	localparam int EEPROM_WAIT_NS  = 4_000_000;
	localparam int ERASE_WAIT_NS   = 9_000_000;
	localparam int DEV_RST_MIN_NS  = 2_500;
	localparam int DEV_CLK_NS      = 1_000;

	localparam int SCK_HALF_CYC    = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_CYC     = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLASH_WAIT_CYC  = (FLASH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EEPROM_WAIT_CYC = (EEPROM_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_WAIT_CYC  = (ERASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_CYC       = (DEV_RST_MIN_NS + 2 * DEV_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int CNT_W = 18;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		SEQ_IDLE    = 5'h01,
		SEQ_STARTUP = 5'h02,
		SEQ_SHIFT   = 5'h04,
		SEQ_WAIT    = 5'h08,
		SEQ_PULSE   = 5'h10
	} isph_seq_type;

	typedef enum logic [1:0] {
		WAIT_NONE   = 2'h0,
		WAIT_FLASH  = 2'h1,
		WAIT_EEPROM = 2'h2,
		WAIT_ERASE  = 2'h3
	} isph_wait_type;

endpackage : isph_pkg

// file: src/isph_host.sv
// Serial programming host: AXI4-Lite registers to the device's four-wire port
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Operation
// (R1) Calibration bytes at 0x01, 0x03 are device's
// (R2) Signature bytes at 0x00, 0x02, 0x04
// (R3) Device loads 8 MHz trim at reset
// (R4) Legacy mode loads 6.4 MHz trim instead
// (R5) Program page 16 or 32 words by address
// (R6) EEPROM page four bytes, low two bits
// (R7) Programming only while reset pin held low
// (R8) Programming enable frame must come first
// (R9) EEPROM write erases target location itself
// (R10) Chip erase sets all locations to 0xFF
// (R11) SCK low and high over two device clocks; SCK_HALF_NS gives 400 ns halves, under two 1000 ns DEV_CLK_NS clocks
// (R12) Drive MOSI on fall, sample on rise
// (R13) SCK low at power-up; reset pulse otherwise
// (R14) Wait 20 ms before programming enable
// (R15) Device echoes 0x53 during third byte
// (R16) Always shift four bytes; resync by pulse
// (R17) Load low byte first, then write page
// (R18) No access until page write finished
// (R19) Byte EEPROM write carries address and data
// (R20) EEPROM page write alters loaded bytes only
// (R21) Read returns stored content on MISO
// (R22) Release reset high to end session
// (R23) Wait 4.5, 4.0 or 9.0 ms
// (R24) Poll bit 0 high means still busy
// (R25) Four bytes MSB first as one frame
module isph_host #(
	parameter int unsigned STARTUP_CYCLES     = isph_pkg::STARTUP_CYC,
	parameter int unsigned FLASH_WAIT_CYCLES  = isph_pkg::FLASH_WAIT_CYC,
	parameter int unsigned EEPROM_WAIT_CYCLES = isph_pkg::EEPROM_WAIT_CYC,
	parameter int unsigned ERASE_WAIT_CYCLES  = isph_pkg::ERASE_WAIT_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             isp_reset_n,
	output logic             isp_sck,
	output logic             isp_mosi,
	input  wire logic        isp_miso
);

	localparam logic [4:0] LAST_BIT = 5'd31;
	localparam logic [isph_pkg::CNT_W-1:0] HALF_LOAD = isph_pkg::CNT_W'(isph_pkg::SCK_HALF_CYC - 1);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	isph_pkg::isph_seq_type  seq_q;
	isph_pkg::isph_wait_type wait_kind_q;
	logic                    awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]              bresp_q, rresp_q;
	logic [31:0]             rdata_q, rdata_d;
	logic                    rmapped_d;
	logic                    session_q, sess_prev_q;
	logic                    start_req_q, pulse_req_q;
	logic [31:0]             tx_q, rx_q;
	logic                    done_q, refused_q, enabled_q, echo_q, dev_busy_q;
	logic [isph_pkg::CNT_W-1:0] cnt_q, div_q;
	logic                    sck_q, mosi_q, reset_pin_q;
	logic [4:0]              bit_q;
	logic                    miso_m_q, miso_s_q;
	logic                    wr_fire, rd_fire, is_enable, start_ok, fall_last, wr_ctrl, wr_status;
	logic [isph_pkg::CNT_W-1:0] wait_load;

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign isp_reset_n   = reset_pin_q;
	assign isp_sck       = sck_q;
	assign isp_mosi      = mosi_q;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Address and data are taken together, one write in flight
	assign wr_fire   = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
	assign rd_fire   = s_axi_arvalid && !arready_q && !rvalid_q;
	assign wr_ctrl   = wr_fire && (s_axi_awaddr == isph_pkg::OFS_CTRL);
	assign wr_status = wr_fire && (s_axi_awaddr == isph_pkg::OFS_STATUS) && s_axi_wstrb[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= isph_pkg::RESP_OKAY;
		end
		else
		begin
			awready_q <= wr_fire;
			wready_q  <= wr_fire;
			if (wr_fire)
				bresp_q <= (s_axi_awaddr == isph_pkg::OFS_CTRL || s_axi_awaddr == isph_pkg::OFS_TX ||
					s_axi_awaddr == isph_pkg::OFS_STATUS) ? isph_pkg::RESP_OKAY : isph_pkg::RESP_SLVERR;
			if (awready_q)
				bvalid_q <= 1'b1;
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	always_comb
	begin
		rdata_d   = 32'h0000_0000;
		rmapped_d = 1'b1;
		case (s_axi_araddr)
			isph_pkg::OFS_CTRL:
			begin
				rdata_d[isph_pkg::CTRL_SESSION_BIT] = session_q;
				rdata_d[isph_pkg::CTRL_WAIT_LSB +: 2] = wait_kind_q;
			end
			isph_pkg::OFS_TX: rdata_d = tx_q;
			isph_pkg::OFS_RX: rdata_d = rx_q;
			isph_pkg::OFS_STATUS:
			begin
				rdata_d[isph_pkg::ST_BUSY_BIT]     = (seq_q != isph_pkg::SEQ_IDLE);
				rdata_d[isph_pkg::ST_DONE_BIT]     = done_q;
				rdata_d[isph_pkg::ST_REFUSED_BIT]  = refused_q;
				rdata_d[isph_pkg::ST_ENABLED_BIT]  = enabled_q;
				rdata_d[isph_pkg::ST_ECHO_BIT]     = echo_q;
				rdata_d[isph_pkg::ST_DEV_BUSY_BIT] = dev_busy_q;
			end
			default: rmapped_d = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= isph_pkg::RESP_OKAY;
		end
		else
		begin
			arready_q <= rd_fire;
			if (rd_fire)
			begin
				rdata_q <= rdata_d;
				rresp_q <= rmapped_d ? isph_pkg::RESP_OKAY : isph_pkg::RESP_SLVERR;
			end
			if (arready_q)
				rvalid_q <= 1'b1;
			else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			session_q   <= 1'b0;
			sess_prev_q <= 1'b0;
			wait_kind_q <= isph_pkg::WAIT_NONE;
			start_req_q <= 1'b0;
			pulse_req_q <= 1'b0;
		end
		else
		begin
			sess_prev_q <= session_q;
			start_req_q <= wr_ctrl && s_axi_wstrb[1] && s_axi_wdata[isph_pkg::CTRL_START_BIT];
			pulse_req_q <= wr_ctrl && s_axi_wstrb[1] && s_axi_wdata[isph_pkg::CTRL_PULSE_BIT];
			if (wr_ctrl && s_axi_wstrb[0])
			begin
				session_q   <= s_axi_wdata[isph_pkg::CTRL_SESSION_BIT];
				wait_kind_q <= isph_pkg::isph_wait_type'(s_axi_wdata[isph_pkg::CTRL_WAIT_LSB +: 2]);
			end
		end
	end

	// Frame is frozen while it shifts
	for (genvar i = 0; i < 4; i++)
	begin : g_tx_lane
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				tx_q[8*i +: 8] <= isph_pkg::RESET_TX[8*i +: 8];
			else if (wr_fire && s_axi_awaddr == isph_pkg::OFS_TX && s_axi_wstrb[i] && seq_q == isph_pkg::SEQ_IDLE)
				tx_q[8*i +: 8] <= s_axi_wdata[8*i +: 8]; // [R5] [R6] [R17] [R19] [R20]
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	assign is_enable = (tx_q[31:24] == isph_pkg::OPC_ENABLE) && (tx_q[23:16] == isph_pkg::ECHO_ENABLE);
	assign start_ok  = start_req_q && seq_q == isph_pkg::SEQ_IDLE && session_q && sess_prev_q &&
		(enabled_q || is_enable); // [R8] [R18]
	assign fall_last = seq_q == isph_pkg::SEQ_SHIFT && div_q == '0 && sck_q && bit_q == LAST_BIT;

	always_comb
	begin
		case (wait_kind_q) // [R23]
			isph_pkg::WAIT_FLASH:  wait_load = isph_pkg::CNT_W'(FLASH_WAIT_CYCLES - 1);
			isph_pkg::WAIT_EEPROM: wait_load = isph_pkg::CNT_W'(EEPROM_WAIT_CYCLES - 1);
			isph_pkg::WAIT_ERASE:  wait_load = isph_pkg::CNT_W'(ERASE_WAIT_CYCLES - 1);
			default:               wait_load = '0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !session_q)
		begin
			seq_q <= isph_pkg::SEQ_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			case (seq_q)
				isph_pkg::SEQ_IDLE:
				begin
					if (!sess_prev_q)
					begin
						seq_q <= isph_pkg::SEQ_STARTUP; // [R14]
						cnt_q <= isph_pkg::CNT_W'(STARTUP_CYCLES - 1);
					end
					else if (pulse_req_q)
					begin
						seq_q <= isph_pkg::SEQ_PULSE; // [R13] [R16]
						cnt_q <= isph_pkg::CNT_W'(isph_pkg::PULSE_CYC - 1);
					end
					else if (start_ok)
						seq_q <= isph_pkg::SEQ_SHIFT;
				end
				isph_pkg::SEQ_STARTUP, isph_pkg::SEQ_WAIT:
				begin
					if (cnt_q == '0)
						seq_q <= isph_pkg::SEQ_IDLE;
					else
						cnt_q <= cnt_q - 1'b1;
				end
				isph_pkg::SEQ_SHIFT:
				begin
					if (fall_last)
					begin
						seq_q <= (wait_kind_q == isph_pkg::WAIT_NONE) ? isph_pkg::SEQ_IDLE : isph_pkg::SEQ_WAIT;
						cnt_q <= wait_load;
					end
				end
				isph_pkg::SEQ_PULSE:
				begin
					if (cnt_q == '0)
					begin
						// Device restarts; pin falls a cycle after the state, so count one more
						seq_q <= isph_pkg::SEQ_STARTUP;
						cnt_q <= isph_pkg::CNT_W'(STARTUP_CYCLES);
					end
					else
						cnt_q <= cnt_q - 1'b1;
				end
				default: seq_q <= isph_pkg::SEQ_IDLE;
			endcase
		end
	end

	// Reset pin low only in a session and outside a resync pulse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reset_pin_q <= 1'b1;
		else
			reset_pin_q <= !session_q || seq_q == isph_pkg::SEQ_PULSE; // [R7] [R13] [R22]
	end

	// ----------------------------------------------------------------
	// Serial shifter
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			miso_m_q <= 1'b0;
			miso_s_q <= 1'b0;
		end
		else
		begin
			miso_m_q <= isp_miso;
			miso_s_q <= miso_m_q;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !session_q)
		begin
			sck_q  <= 1'b0;
			mosi_q <= 1'b0;
			div_q  <= '0;
			bit_q  <= '0;
		end
		else if (seq_q == isph_pkg::SEQ_IDLE && start_ok)
		begin
			sck_q  <= 1'b0;
			mosi_q <= tx_q[31]; // [R25]
			div_q  <= HALF_LOAD;
			bit_q  <= '0;
		end
		else if (seq_q == isph_pkg::SEQ_SHIFT)
		begin
			if (div_q != '0)
				div_q <= div_q - 1'b1;
			else
			begin
				div_q <= HALF_LOAD; // [R11]
				sck_q <= !sck_q;
				// Next bit goes out just after the falling edge
				if (sck_q && bit_q != LAST_BIT)
				begin
					bit_q  <= bit_q + 1'b1;
					mosi_q <= tx_q[LAST_BIT - 5'd1 - bit_q]; // [R12] [R25]
				end
			end
		end
		else
			sck_q <= 1'b0; // [R13]
	end

	// MISO settled since the device's falling edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_q <= 32'h0000_0000;
		else if (seq_q == isph_pkg::SEQ_SHIFT && div_q == '0 && !sck_q)
			rx_q <= {rx_q[30:0], miso_s_q}; // [R12] [R21]
	end

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done_q     <= 1'b0;
			refused_q  <= 1'b0;
			enabled_q  <= 1'b0;
			echo_q     <= 1'b0;
			dev_busy_q <= 1'b0;
		end
		else
		begin
			// Set wins over a write-one clear in the same cycle
			done_q    <= fall_last || (done_q && !(wr_status && s_axi_wdata[isph_pkg::ST_DONE_BIT]));
			refused_q <= (start_req_q && !start_ok) ||
				(refused_q && !(wr_status && s_axi_wdata[isph_pkg::ST_REFUSED_BIT])); // [R8]
			if (!session_q || seq_q == isph_pkg::SEQ_PULSE)
				enabled_q <= 1'b0;
			else if (fall_last && is_enable)
				enabled_q <= (rx_q[15:8] == isph_pkg::ECHO_ENABLE); // [R15] [R16]
			if (fall_last)
				echo_q <= (rx_q[15:8] == isph_pkg::ECHO_ENABLE);
			if (fall_last && tx_q[31:24] == isph_pkg::OPC_POLL)
				dev_busy_q <= rx_q[0]; // [R24]
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [isph_pkg::CNT_W-1:0] low_cnt_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || reset_pin_q)
			low_cnt_q <= '0;
		else if (low_cnt_q != '1)
			low_cnt_q <= low_cnt_q + 1'b1;
	end

	property p_sck_only_in_session;
		@(posedge aclk) disable iff (!aresetn) sck_q |-> !reset_pin_q;
	endproperty
	a_sck_only_in_session: assert property (p_sck_only_in_session) else $error("SCK high outside session"); // [R7]

	property p_sck_high_width;
		@(posedge aclk) disable iff (!aresetn || !session_q) $rose(sck_q) |-> sck_q [*4];
	endproperty
	a_sck_high_width: assert property (p_sck_high_width) else $error("SCK high phase too short"); // [R11]

	property p_mosi_on_low;
		@(posedge aclk) disable iff (!aresetn || !session_q) $changed(mosi_q) && $past(sck_q) |-> !sck_q;
	endproperty
	a_mosi_on_low: assert property (p_mosi_on_low) else $error("MOSI moved while SCK high"); // [R12]

	property p_msb_first;
		@(posedge aclk) disable iff (!aresetn) $rose(sck_q) |-> mosi_q == tx_q[LAST_BIT - bit_q];
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("Bit order wrong"); // [R25]

	property p_startup_wait;
		@(posedge aclk) disable iff (!aresetn) start_ok |-> low_cnt_q >= isph_pkg::CNT_W'(STARTUP_CYCLES);
	endproperty
	a_startup_wait: assert property (p_startup_wait) else $error("Frame before settle time"); // [R14]

	property p_enable_first;
		@(posedge aclk) disable iff (!aresetn)
			seq_q == isph_pkg::SEQ_SHIFT && !enabled_q |-> tx_q[31:16] == {isph_pkg::OPC_ENABLE, isph_pkg::ECHO_ENABLE};
	endproperty
	a_enable_first: assert property (p_enable_first) else $error("Frame before enable"); // [R8]

	property p_full_frame;
		@(posedge aclk) disable iff (!aresetn || !session_q)
			$fell(seq_q == isph_pkg::SEQ_SHIFT) |-> $past(bit_q) == LAST_BIT && !sck_q;
	endproperty
	a_full_frame: assert property (p_full_frame) else $error("Frame cut short"); // [R16]

	property p_release_reset;
		@(posedge aclk) disable iff (!aresetn) $fell(session_q) |=> reset_pin_q && !sck_q;
	endproperty
	a_release_reset: assert property (p_release_reset) else $error("Reset not released"); // [R22]

	property p_pulse_high;
		@(posedge aclk) disable iff (!aresetn || !session_q)
			$rose(seq_q == isph_pkg::SEQ_PULSE) |=> (reset_pin_q && !sck_q) [*3];
	endproperty
	a_pulse_high: assert property (p_pulse_high) else $error("Resync pulse malformed"); // [R13]

	property p_wait_blocks;
		@(posedge aclk) disable iff (!aresetn || !session_q)
			seq_q == isph_pkg::SEQ_WAIT && cnt_q != '0 |=> seq_q == isph_pkg::SEQ_WAIT;
	endproperty
	a_wait_blocks: assert property (p_wait_blocks) else $error("Frame during write delay"); // [R18] [R23]

endmodule : isph_host

// file: bench/isph_dev_model.sv
// Behavioural model of the device behind the serial programming port
`timescale 1ns/100ps
module isph_dev_model #(
	parameter logic [7:0] SIG0     = 8'h5A, // Arbitrary identity value
	parameter logic [7:0] SIG1     = 8'hC3, // Arbitrary identity value
	parameter logic [7:0] SIG2     = 8'h3C, // Arbitrary identity value
	parameter logic [7:0] CAL8     = 8'h7B,
	parameter logic [7:0] CAL6     = 8'h64,
	parameter bit         LEGACY   = 1'b0,
	parameter int         PAGE_W   = 32,
	parameter int         BUSY_CYC = 240
) (
	input  wire logic dev_clk,
	input  wire logic isp_reset_n,
	input  wire logic isp_sck,
	input  wire logic isp_mosi,
	output logic      isp_miso,
	output logic      timing_bad
);
	logic [7:0]  info [0:4];
	logic [15:0] flash [0:255];
	logic [15:0] pbuf [0:31];
	logic [7:0]  eep [0:63];
	logic [7:0]  ebuf [0:3];
	logic [3:0]  emask;
	logic [31:0] fr;
	logic [7:0]  sh;
	logic [7:0]  oscillator_trim_register;
	logic        en;
	logic        last;
	int          cnt;
	int          busy;
	int          ph;

	initial
	begin
		info = '{SIG0, CAL8, SIG1, CAL6, SIG2};
		emask = 4'h0;
		sh = 8'h00;
		fr = 32'h0;
		en = 1'b0;
		cnt = 0;
		busy = 0;
		ph = 9;
		last = 1'b0;
		isp_miso = 1'b0;
		timing_bad = 1'b0;
	end

	always @(negedge isp_reset_n)
	begin
		oscillator_trim_register = LEGACY ? CAL6 : CAL8;
		en = 1'b0;
		cnt = 0;
	end

	function automatic logic [7:0] rd(input logic [23:0] f);
		case (f[23:16])
			8'h30: rd = info[{f[1:0], 1'b0}];
			8'h38: rd = info[{1'b0, f[0], 1'b1}];
			8'hF0: rd = {7'h00, busy != 0};
			8'hA0: rd = eep[f[5:0]];
			8'h20: rd = flash[f[7:0]][7:0];
			8'h28: rd = flash[f[7:0]][15:8];
			default: rd = 8'h00;
		endcase
	endfunction : rd

	// Frames other than a poll or the enable arriving while busy are lost, as a real array would corrupt them
	task automatic exec(input logic [31:0] f);
		int k;
		if (f[31:16] == 16'hAC53) en = 1'b1;
		if (!en || (busy != 0 && f[31:24] != 8'hF0)) return;
		case (f[31:24])
			8'hAC:
			begin
				if (f[23:16] == 8'h80)
				begin
					for (k = 0; k < 256; k++) flash[k] = 16'hFFFF;
					for (k = 0; k < 64; k++) eep[k] = 8'hFF;
					busy = BUSY_CYC;
				end
			end
			8'h40: pbuf[f[12:8] & 5'(PAGE_W - 1)][7:0] = f[7:0];
			8'h48: pbuf[f[12:8] & 5'(PAGE_W - 1)][15:8] = f[7:0];
			8'h4C:
			begin
				for (k = 0; k < PAGE_W; k++) flash[(f[15:8] & ~8'(PAGE_W - 1)) | 8'(k)] = pbuf[k];
				busy = BUSY_CYC;
			end
			8'hC0:
			begin
				eep[f[13:8]] = f[7:0];
				busy = BUSY_CYC;
			end
			8'hC1:
			begin
				ebuf[f[9:8]] = f[7:0];
				emask[f[9:8]] = 1'b1;
			end
			8'hC2:
			begin
				for (k = 0; k < 4; k++) if (emask[k]) eep[{f[13:10], 2'(k)}] = ebuf[k];
				emask = 4'h0;
				busy = BUSY_CYC;
			end
			default: ;
		endcase
	endtask : exec

	always @(posedge isp_sck)
	begin
		if (!isp_reset_n)
		begin
			fr = {fr[30:0], isp_mosi};
			cnt = cnt + 1;
			if (cnt == 16) sh = fr[7:0];
			if (cnt == 24) sh = rd(fr[23:0]);
			if (cnt == 32)
			begin
				exec(fr);
				cnt = 0;
			end
		end
	end

	always @(negedge isp_sck)
	begin
		if (!isp_reset_n)
		begin
			isp_miso = sh[7];
			sh = {sh[6:0], ~sh[7]};
		end
	end

	// Released output toggles so a stale bit never looks valid
	always @(posedge dev_clk)
	begin
		if (busy > 0) busy = busy - 1;
		if (isp_reset_n) isp_miso = ~isp_miso;
		if (isp_sck != last)
		begin
			if (ph <= 2 && !isp_reset_n) timing_bad = 1'b1;
			ph = 1;
			last = isp_sck;
		end
		else
			ph = ph + 1;
	end
endmodule : isph_dev_model

// file: bench/tb_top.sv
// Self-checking bench for the serial programming host
`timescale 1ns/100ps
module tb_top;
	localparam logic [7:0] SIG0 = 8'h5A; // Arbitrary identity value
	localparam logic [7:0] SIG1 = 8'hC3; // Arbitrary identity value
	localparam logic [7:0] SIG2 = 8'h3C; // Arbitrary identity value
	localparam logic [7:0] CAL8 = 8'h7B;
	localparam logic [7:0] CAL6 = 8'h64;

	logic        aclk, aresetn, dev_clk;
	logic [7:0]  awaddr, araddr, a, d, e;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, v, rx;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        rst_n, sck, mosi, miso, timing_bad;
	int          err_total = 0;
	int          tests_run = 0;
	int          seed = 34312;
	int          n;
	int          hi_n = 0;
	int          hi_last = 0;

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial
	begin
		dev_clk = 1'b0;
		forever #62.5 dev_clk = ~dev_clk;
	end

	// Length of the last high stretch on the device reset pin
	always @(posedge aclk)
	begin
		if (rst_n === 1'b1)
			hi_n <= hi_n + 1;
		else
		begin
			if (hi_n != 0) hi_last <= hi_n;
			hi_n <= 0;
		end
	end

	isph_host #(.STARTUP_CYCLES(50), .FLASH_WAIT_CYCLES(400), .EEPROM_WAIT_CYCLES(400), .ERASE_WAIT_CYCLES(400))
	isph_host_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.isp_reset_n(rst_n), .isp_sck(sck), .isp_mosi(mosi), .isp_miso(miso)
	);

	isph_dev_model #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CAL8(CAL8), .CAL6(CAL6)) isph_dev_model_i (
		.dev_clk(dev_clk), .isp_reset_n(rst_n), .isp_sck(sck), .isp_mosi(mosi),
		.isp_miso(miso), .timing_bad(timing_bad)
	);

	// --------------
	// Tasks
	// --------------
	task give_verdict();
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task axi_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		dt = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task rd_st();
		axi_rd(isph_pkg::OFS_STATUS, v);
	endtask : rd_st

	task wait_idle();
		do
			rd_st();
		while (v[isph_pkg::ST_BUSY_BIT] !== 1'b0);
	endtask : wait_idle

	task frame(input logic [31:0] tx, input logic [1:0] w);
		axi_wr(isph_pkg::OFS_TX, tx, 4'hF);
		axi_wr(isph_pkg::OFS_CTRL, {23'h0, 1'b1, 5'h0, w, 1'b1}, 4'h3);
		do
			rd_st();
		while (v[isph_pkg::ST_DONE_BIT] !== 1'b1);
		wait_idle();
		axi_wr(isph_pkg::OFS_STATUS, 32'h2, 4'h1);
		axi_rd(isph_pkg::OFS_RX, rx);
	endtask : frame

	task try_early();
		axi_wr(isph_pkg::OFS_TX, 32'h3000_0000, 4'hF);
		axi_wr(isph_pkg::OFS_CTRL, 32'h101, 4'h3);
		rd_st();
		check(v[isph_pkg::ST_REFUSED_BIT], 1'b1);
		axi_wr(isph_pkg::OFS_STATUS, 32'h4, 4'h1);
	endtask : try_early

	task enable();
		frame({isph_pkg::OPC_ENABLE, isph_pkg::ECHO_ENABLE, 16'h0}, 2'h0);
		check(rx[15:8], isph_pkg::ECHO_ENABLE);
		rd_st();
		check(v[isph_pkg::ST_ENABLED_BIT], 1'b1);
		check(v[isph_pkg::ST_ECHO_BIT], 1'b1);
	endtask : enable

	function automatic logic [7:0] info_exp(input int k);
		case (k)
			0: info_exp = SIG0;
			1: info_exp = CAL8;
			2: info_exp = SIG1;
			3: info_exp = CAL6;
			default: info_exp = SIG2;
		endcase
	endfunction : info_exp

	// --------------
	// Sequence
	// --------------
	initial
	begin
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		check(rst_n, 1'b1);
		check(sck, 1'b0);
		rd_st();
		check(v, 32'h0);
		axi_rd(isph_pkg::OFS_CTRL, v);
		check(v, 32'h0);
		axi_rd(isph_pkg::OFS_TX, v);
		check(v, isph_pkg::RESET_TX);
		axi_rd(8'h10, v);
		check(resp, isph_pkg::RESP_SLVERR);
		axi_wr(8'h14, 32'h1, 4'hF);
		check(resp, isph_pkg::RESP_SLVERR);
		axi_wr(isph_pkg::OFS_CTRL, 32'h100, 4'h2);
		rd_st();
		check(v[isph_pkg::ST_REFUSED_BIT], 1'b1);
		check(rst_n, 1'b1);
		axi_wr(isph_pkg::OFS_STATUS, 32'h4, 4'h1);
		axi_wr(isph_pkg::OFS_CTRL, 32'h1, 4'h1);
		wait_idle();
		check(rst_n, 1'b0);
		check(sck, 1'b0);
		try_early();
		enable();
		for (n = 0; n < 5; n++)
		begin
			frame({(n % 2 == 1) ? 8'h38 : 8'h30, 8'h00, 8'(n / 2), 8'h00}, 2'h0);
			check(rx[7:0], info_exp(n));
		end
		frame(32'hAC80_0000, 2'h0);
		frame({isph_pkg::OPC_POLL, 24'h0}, 2'h0);
		check(rx[0], 1'b1);
		rd_st();
		check(v[isph_pkg::ST_DEV_BUSY_BIT], 1'b1);
		n = 0;
		while (rx[0] !== 1'b0 && n < 8)
		begin
			frame({isph_pkg::OPC_POLL, 24'h0}, 2'h0);
			n++;
		end
		check(rx[0], 1'b0);
		rd_st();
		check(v[isph_pkg::ST_DEV_BUSY_BIT], 1'b0);
		a = 8'($random(seed));
		frame({16'hA000, 2'b00, a[5:0], 8'h00}, 2'h0);
		check(rx[7:0], 8'hFF);
		frame({16'h2000, a, 8'h00}, 2'h0);
		check(rx[7:0], 8'hFF);
		repeat (3)
		begin
			a = 8'($random(seed)) & 8'h1F;
			d = 8'($random(seed));
			frame({16'hC000, a, ~d}, 2'h2);
			frame({16'hC000, a, d}, 2'h2);
			frame({16'hA000, a, 8'h00}, 2'h0);
			check(rx[7:0], d);
		end
		d = 8'($random(seed));
		e = ~d;
		frame({16'hC100, 8'h01, d}, 2'h0);
		frame({16'hC100, 8'h02, e}, 2'h0);
		frame({16'hC200, 8'h3C, 8'h00}, 2'h3);
		axi_rd(isph_pkg::OFS_CTRL, v);
		check(v, 32'h7);
		for (n = 0; n < 4; n++)
		begin
			frame({16'hA000, 8'h3C | 8'(n), 8'h00}, 2'h0);
			check(rx[7:0], (n == 1) ? d : ((n == 2) ? e : 8'hFF));
		end
		a = 8'($random(seed));
		frame({16'h4000, a, d}, 2'h0);
		frame({16'h4800, a, e}, 2'h0);
		frame({16'h4C00, a, 8'h00}, 2'h1);
		frame({16'h2000, a, 8'h00}, 2'h0);
		check(rx[7:0], d);
		frame({16'h2800, a, 8'h00}, 2'h0);
		check(rx[7:0], e);
		frame({16'h2000, a ^ 8'h20, 8'h00}, 2'h0);
		check(rx[7:0], 8'hFF);
		axi_wr(isph_pkg::OFS_CTRL, 32'h201, 4'h3);
		wait_idle();
		check(hi_last >= isph_pkg::PULSE_CYC, 1'b1);
		check(rst_n, 1'b0);
		rd_st();
		check(v[isph_pkg::ST_ENABLED_BIT], 1'b0);
		try_early();
		enable();
		axi_wr(isph_pkg::OFS_CTRL, 32'h0, 4'h1);
		repeat (3) @(posedge aclk);
		check(rst_n, 1'b1);
		check(timing_bad, 1'b0);
		check(isph_dev_model_i.oscillator_trim_register, CAL8);
		give_verdict();
	end

	// Run needs about 1.3 ms; a hang is cut off well beyond that
	initial
	begin
		#10_000_000;
		err_total++;
		give_verdict();
	end
endmodule : tb_top
